// ===== verilog/ptp_unit_pkg.sv
// Package with the register map, field layout and carrier types of the unit selector and event status bank.
package ptp_unit_pkg;

    // ********************************
    // Register offsets (byte addresses)
    // ********************************
    localparam int          ADDR_W             = 12;
    localparam logic [11:0] OFS_UNIT_SELECTOR  = 12'h520;
    localparam logic [11:0] OFS_TRIG_STATUS    = 12'h524;
    localparam logic [11:0] OFS_EVENT_IRQ      = 12'h528;
    localparam logic [11:0] OFS_STAMP_CONTROL  = 12'h52C;
    localparam logic [11:0] OFS_PULSE_CONTROL  = 12'h540;
    localparam logic [11:0] OFS_EVENT_IRQ_MASK = 12'h5C0;
    localparam logic [11:0] OFS_WINDOW_FIRST   = 12'h52C;
    localparam logic [11:0] OFS_WINDOW_LAST    = 12'h5B3;

    // ********************************
    // Field positions
    // ********************************
    localparam int POS_STAMP_SELECT  = 8;
    localparam int POS_PULSE_SELECT  = 0;
    localparam int POS_PULSE_ERROR   = 16;
    localparam int POS_PULSE_DONE    = 0;
    localparam int POS_PULSE_IRQ     = 16;
    localparam int POS_STAMP_IRQ     = 0;
    localparam int POS_STAMP_IRQ_EN  = 5;
    localparam int POS_PULSE_ACTIVE  = 4;
    localparam int POS_PULSE_ENABLE  = 3;
    localparam int POS_PULSE_NOTIFY  = 0;

    // ********************************
    // Unit counts, codes and reset values
    // ********************************
    localparam int          NUM_PULSE_UNITS   = 3;
    localparam int          NUM_STAMP_UNITS   = 2;
    localparam logic [1:0]  PULSE_SEL_RSVD    = 2'h3;
    localparam logic [1:0]  RST_PULSE_SELECT  = 2'h0;
    localparam logic        RST_STAMP_SELECT  = 1'b0;
    localparam logic [2:0]  RST_PULSE_FLAGS   = 3'h0;
    localparam logic [1:0]  RST_STAMP_FLAGS   = 2'h0;
    localparam logic [31:0] RST_READ_DATA     = 32'h0000_0000;

    // Event pulses coming from the trigger and timestamp units.
    typedef struct packed {
        logic [2:0] pulse_error;
        logic [2:0] pulse_done;
        logic [1:0] stamp_event;
    } unit_events_s;

    // Control levels going to the trigger and timestamp units.
    typedef struct packed {
        logic [1:0] pulse_unit_select;
        logic       stamp_unit_select;
        logic [2:0] pulse_enable;
        logic [2:0] pulse_notify_enable;
        logic [1:0] stamp_irq_enable;
    } unit_ctrl_s;

endpackage

// ===== verilog/ptp_unit_index_and_event_status.sv
// Unit selector, indexed unit control window and trigger/timestamp event status with interrupt.
`timescale 1ns/100ps
module ptp_unit_index_and_event_status
    import ptp_unit_pkg::*;
(
    // Clock and reset
    input  wire logic              clk,
    input  wire logic              rst,
    // Avalon-MM slave
    input  wire logic [ADDR_W-1:0] address,
    input  wire logic              read,
    input  wire logic              write,
    input  wire logic [3:0]        byteenable,
    input  wire logic [31:0]       writedata,
    output      logic [31:0]       readdata,
    output      logic              waitrequest,
    // Unit side
    input  wire unit_events_s      unit_events,
    output      unit_ctrl_s        unit_ctrl,
    // Interrupts
    output      logic              event_irq_summary,
    output      logic              irq
);

    // ****************************************************************
    // Bus handshake
    // ****************************************************************
    logic        waitrequest_r;
    logic [31:0] readdata_r;
    logic [31:0] rd_val;
    logic [31:0] be_mask;
    logic        wr_fire;
    logic        rd_take;

    // Every access is answered one edge after it is seen, so a master never hangs on a hole in the map.
    always_ff @(posedge clk) begin
        if (rst) begin
            waitrequest_r <= 1'b1;
        end else if ((read || write) && waitrequest_r) begin
            waitrequest_r <= 1'b0;
        end else begin
            waitrequest_r <= 1'b1;
        end
    end

    assign wr_fire = write && !waitrequest_r;
    assign rd_take = read && waitrequest_r;
    assign be_mask = {{8{byteenable[3]}}, {8{byteenable[2]}}, {8{byteenable[1]}}, {8{byteenable[0]}}};

    // ****************************************************************
    // Unit selector
    // ****************************************************************
    logic       stamp_sel_r;
    logic [1:0] pulse_sel_r;
    logic       pulse_sel_ok;
    logic       sel_write;
    logic       win_stamp_wr;
    logic       win_pulse_wr;

    assign sel_write    = wr_fire && (address == OFS_UNIT_SELECTOR);
    assign pulse_sel_ok = (pulse_sel_r != PULSE_SEL_RSVD);
    assign win_stamp_wr = wr_fire && (address == OFS_STAMP_CONTROL);
    assign win_pulse_wr = wr_fire && (address == OFS_PULSE_CONTROL) && pulse_sel_ok;

    always_ff @(posedge clk) begin
        if (rst) begin
            stamp_sel_r <= RST_STAMP_SELECT;
            pulse_sel_r <= RST_PULSE_SELECT;
        end else if (sel_write) begin
            if (be_mask[POS_STAMP_SELECT]) begin
                stamp_sel_r <= writedata[POS_STAMP_SELECT];
            end
            if (be_mask[POS_PULSE_SELECT]) begin
                pulse_sel_r <= writedata[POS_PULSE_SELECT +: 2];
            end
        end
    end

    // ****************************************************************
    // Indexed unit controls
    // ****************************************************************
    logic [2:0] pulse_en_r;
    logic [2:0] notify_r;
    logic [1:0] stamp_ie_r;

    // Bit 3 of the timestamp control window steers the trigger unit, bit 5 the timestamp unit.
    always_ff @(posedge clk) begin
        if (rst) begin
            pulse_en_r <= RST_PULSE_FLAGS;
        end else begin
            for (int k = 0; k < NUM_PULSE_UNITS; k++) begin
                if (unit_events.pulse_done[k]) begin
                    pulse_en_r[k] <= 1'b0;
                end else if (win_stamp_wr && pulse_sel_ok && (pulse_sel_r == 2'(k)) &&
                             be_mask[POS_PULSE_ENABLE]) begin
                    pulse_en_r[k] <= writedata[POS_PULSE_ENABLE];
                end
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            notify_r <= RST_PULSE_FLAGS;
        end else begin
            for (int k = 0; k < NUM_PULSE_UNITS; k++) begin
                if (win_pulse_wr && (pulse_sel_r == 2'(k)) && be_mask[POS_PULSE_NOTIFY]) begin
                    notify_r[k] <= writedata[POS_PULSE_NOTIFY];
                end
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            stamp_ie_r <= RST_STAMP_FLAGS;
        end else begin
            for (int k = 0; k < NUM_STAMP_UNITS; k++) begin
                if (win_stamp_wr && (stamp_sel_r == 1'(k)) && be_mask[POS_STAMP_IRQ_EN]) begin
                    stamp_ie_r[k] <= writedata[POS_STAMP_IRQ_EN];
                end
            end
        end
    end

    // ****************************************************************
    // Event status flags
    // ****************************************************************
    logic [2:0] err_r;
    logic [2:0] done_r;
    logic [2:0] trig_irq_r;
    logic [1:0] stamp_irq_r;
    logic       st0_write;
    logic       st1_write;
    logic [31:0] w1c;

    assign st0_write = wr_fire && (address == OFS_TRIG_STATUS);
    assign st1_write = wr_fire && (address == OFS_EVENT_IRQ);
    assign w1c       = writedata & be_mask;

    // In every flag below a new event wins over a clear arriving in the same cycle.
    always_ff @(posedge clk) begin
        if (rst) begin
            err_r <= RST_PULSE_FLAGS;
        end else begin
            for (int k = 0; k < NUM_PULSE_UNITS; k++) begin
                if (unit_events.pulse_error[k] && notify_r[k]) begin
                    err_r[k] <= 1'b1;
                end else if (st0_write && w1c[POS_PULSE_ERROR + k]) begin
                    err_r[k] <= 1'b0;
                end else if (win_stamp_wr && pulse_sel_ok && (pulse_sel_r == 2'(k)) &&
                             be_mask[POS_PULSE_ENABLE] && !writedata[POS_PULSE_ENABLE]) begin
                    err_r[k] <= 1'b0;
                end
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            done_r <= RST_PULSE_FLAGS;
        end else begin
            for (int k = 0; k < NUM_PULSE_UNITS; k++) begin
                if (unit_events.pulse_done[k] && notify_r[k]) begin
                    done_r[k] <= 1'b1;
                end else if (st0_write && w1c[POS_PULSE_DONE + k]) begin
                    done_r[k] <= 1'b0;
                end
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            trig_irq_r <= RST_PULSE_FLAGS;
        end else begin
            for (int k = 0; k < NUM_PULSE_UNITS; k++) begin
                if ((unit_events.pulse_error[k] || unit_events.pulse_done[k]) && notify_r[k]) begin
                    trig_irq_r[k] <= 1'b1;
                end else if (st1_write && w1c[POS_PULSE_IRQ + k]) begin
                    trig_irq_r[k] <= 1'b0;
                end
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            stamp_irq_r <= RST_STAMP_FLAGS;
        end else begin
            for (int k = 0; k < NUM_STAMP_UNITS; k++) begin
                if (unit_events.stamp_event[k] && stamp_ie_r[k]) begin
                    stamp_irq_r[k] <= 1'b1;
                end else if (st1_write && w1c[POS_STAMP_IRQ + k]) begin
                    stamp_irq_r[k] <= 1'b0;
                end
            end
        end
    end

    // ****************************************************************
    // Interrupt mask and outputs
    // ****************************************************************
    logic [2:0] mask_trig_r;
    logic [1:0] mask_stamp_r;
    logic       summary_r;
    logic       irq_r;
    logic       any_flag;

    always_ff @(posedge clk) begin
        if (rst) begin
            mask_trig_r  <= RST_PULSE_FLAGS;
            mask_stamp_r <= RST_STAMP_FLAGS;
        end else if (wr_fire && (address == OFS_EVENT_IRQ_MASK)) begin
            for (int k = 0; k < NUM_PULSE_UNITS; k++) begin
                if (be_mask[POS_PULSE_IRQ + k]) begin
                    mask_trig_r[k] <= writedata[POS_PULSE_IRQ + k];
                end
            end
            for (int k = 0; k < NUM_STAMP_UNITS; k++) begin
                if (be_mask[POS_STAMP_IRQ + k]) begin
                    mask_stamp_r[k] <= writedata[POS_STAMP_IRQ + k];
                end
            end
        end
    end

    assign any_flag = (|trig_irq_r) || (|stamp_irq_r);

    always_ff @(posedge clk) begin
        if (rst) begin
            summary_r <= 1'b0;
            irq_r     <= 1'b0;
        end else begin
            summary_r <= any_flag;
            irq_r     <= (|(trig_irq_r & mask_trig_r)) || (|(stamp_irq_r & mask_stamp_r));
        end
    end

    // ****************************************************************
    // Read mux
    // ****************************************************************
    // reserved bits zero
    always_comb begin
        rd_val = RST_READ_DATA;
        unique case (address)
            OFS_UNIT_SELECTOR: begin
                rd_val[POS_STAMP_SELECT]      = stamp_sel_r;
                rd_val[POS_PULSE_SELECT +: 2] = pulse_sel_r;
            end
            OFS_TRIG_STATUS: begin
                rd_val[POS_PULSE_ERROR +: 3] = err_r;
                rd_val[POS_PULSE_DONE +: 3]  = done_r;
            end
            OFS_EVENT_IRQ: begin
                rd_val[POS_PULSE_IRQ +: 3] = trig_irq_r;
                rd_val[POS_STAMP_IRQ +: 2] = stamp_irq_r;
            end
            OFS_STAMP_CONTROL: begin
                rd_val[POS_STAMP_IRQ_EN] = stamp_ie_r[stamp_sel_r];
                if (pulse_sel_ok) begin
                    rd_val[POS_PULSE_ENABLE] = pulse_en_r[pulse_sel_r];
                    rd_val[POS_PULSE_ACTIVE] = pulse_en_r[pulse_sel_r] && !err_r[pulse_sel_r];
                end
            end
            OFS_PULSE_CONTROL: begin
                if (pulse_sel_ok) begin
                    rd_val[POS_PULSE_NOTIFY] = notify_r[pulse_sel_r];
                end
            end
            OFS_EVENT_IRQ_MASK: begin
                rd_val[POS_PULSE_IRQ +: 3] = mask_trig_r;
                rd_val[POS_STAMP_IRQ +: 2] = mask_stamp_r;
            end
            default: begin
                rd_val = RST_READ_DATA;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            readdata_r <= RST_READ_DATA;
        end else if (rd_take) begin
            readdata_r <= rd_val;
        end
    end

    assign readdata          = readdata_r;
    assign waitrequest       = waitrequest_r;
    assign event_irq_summary = summary_r;
    assign irq               = irq_r;
    assign unit_ctrl         = '{pulse_unit_select:   pulse_sel_r,
                                 stamp_unit_select:   stamp_sel_r,
                                 pulse_enable:        pulse_en_r,
                                 pulse_notify_enable: notify_r,
                                 stamp_irq_enable:    stamp_ie_r};

    // ****************************************************************
    // Assertions
    // ****************************************************************
    property p_window_route;
        @(posedge clk) disable iff (rst)
        (win_stamp_wr && pulse_sel_ok && byteenable[0] && writedata[POS_PULSE_ENABLE] &&
         !unit_events.pulse_done[pulse_sel_r]) |=> pulse_en_r[$past(pulse_sel_r)];
    endproperty
    a_window_route: assert property (p_window_route) else $error("window write missed selected unit");

    property p_stamp_sel;
        @(posedge clk) disable iff (rst)
        (sel_write && byteenable[1]) |=> (stamp_sel_r == $past(writedata[POS_STAMP_SELECT]));
    endproperty
    a_stamp_sel: assert property (p_stamp_sel) else $error("timestamp selector not written");

    property p_pulse_sel;
        @(posedge clk) disable iff (rst)
        (sel_write && byteenable[0]) |=> (pulse_sel_r == $past(writedata[1:0]));
    endproperty
    a_pulse_sel: assert property (p_pulse_sel) else $error("trigger selector not written");

    property p_err_set;
        @(posedge clk) disable iff (rst)
        (unit_events.pulse_error[0] && notify_r[0]) |=> err_r[0] ##1 (err_r[0] || $past(wr_fire));
    endproperty
    a_err_set: assert property (p_err_set) else $error("trigger error flag not set");

    property p_err_clr_en;
        @(posedge clk) disable iff (rst)
        (win_stamp_wr && pulse_sel_r == 2'h1 && byteenable[0] && !writedata[POS_PULSE_ENABLE] &&
         !unit_events.pulse_error[1]) |=> !err_r[1];
    endproperty
    a_err_clr_en: assert property (p_err_clr_en) else $error("disable did not clear error");

    property p_done_set;
        @(posedge clk) disable iff (rst)
        (unit_events.pulse_done[2] && notify_r[2]) |=> (done_r[2] && trig_irq_r[2] && !pulse_en_r[2]);
    endproperty
    a_done_set: assert property (p_done_set) else $error("done event not recorded");

    property p_trig_gate;
        @(posedge clk) disable iff (rst)
        $rose(trig_irq_r[0]) |-> $past(notify_r[0]);
    endproperty
    a_trig_gate: assert property (p_trig_gate) else $error("trigger interrupt set while not notifying");

    property p_trig_w1c;
        @(posedge clk) disable iff (rst)
        (st1_write && byteenable[2] && writedata[POS_PULSE_IRQ] && !unit_events.pulse_error[0] &&
         !unit_events.pulse_done[0]) |=> !trig_irq_r[0];
    endproperty
    a_trig_w1c: assert property (p_trig_w1c) else $error("trigger interrupt not cleared");

    property p_stamp_gate;
        @(posedge clk) disable iff (rst)
        $rose(stamp_irq_r[1]) |-> $past(stamp_ie_r[1]);
    endproperty
    a_stamp_gate: assert property (p_stamp_gate) else $error("timestamp interrupt set while disabled");

    property p_summary;
        @(posedge clk) disable iff (rst)
        ##1 (summary_r == $past(any_flag));
    endproperty
    a_summary: assert property (p_summary) else $error("summary bit is not the OR of the flags");

    property p_stamp_ie;
        @(posedge clk) disable iff (rst)
        (win_stamp_wr && byteenable[0] && !stamp_sel_r) |=> (stamp_ie_r[0] == $past(writedata[5]));
    endproperty
    a_stamp_ie: assert property (p_stamp_ie) else $error("timestamp enable not reached through selector");

    property p_self_clear;
        @(posedge clk) disable iff (rst)
        unit_events.pulse_done[1] |=> !pulse_en_r[1];
    endproperty
    a_self_clear: assert property (p_self_clear) else $error("trigger enable did not clear itself");

    property p_reserved;
        @(posedge clk) disable iff (rst)
        (rd_take && address == OFS_EVENT_IRQ) |=> (readdata_r[31:19] == 13'h0000 && readdata_r[15:2] == 14'h0000);
    endproperty
    a_reserved: assert property (p_reserved) else $error("reserved bits read nonzero");

endmodule

// ===== tb/tb_ptp_unit_index_and_event_status.sv
// Self-checking testbench for the unit selector and event status bank.
`timescale 1ns/100ps
module tb_ptp_unit_index_and_event_status
    import ptp_unit_pkg::*;
;
    // Clock and reset
    logic              clk;
    logic              rst;
    // Register bus
    logic [ADDR_W-1:0] address;
    logic              read;
    logic              write;
    logic [3:0]        byteenable;
    logic [31:0]       writedata;
    logic [31:0]       readdata;
    logic              waitrequest;
    // Unit side and interrupts
    unit_events_s      unit_events;
    unit_ctrl_s        unit_ctrl;
    logic              event_irq_summary;
    logic              irq;
    // Bookkeeping
    int                n_mismatch;
    int                total_checks;
    logic [31:0]       rd;

    ptp_unit_index_and_event_status dut (
        .clk               (clk),
        .rst               (rst),
        .address           (address),
        .read              (read),
        .write             (write),
        .byteenable        (byteenable),
        .writedata         (writedata),
        .readdata          (readdata),
        .waitrequest       (waitrequest),
        .unit_events       (unit_events),
        .unit_ctrl         (unit_ctrl),
        .event_irq_summary (event_irq_summary),
        .irq               (irq)
    );

    always #2.5 clk = ~clk;

    // ****************************************
    // Shared tasks
    // ****************************************
    task automatic report_and_stop();
        $display("Checks %0d, mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // The slave's wait time is not assumed; a stuck bus ends the run.
    task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] d, input logic [3:0] be);
        int k;
        @(posedge clk);
        address    <= a;
        writedata  <= d;
        byteenable <= be;
        read       <= !wr;
        write      <= wr;
        for (k = 0; k < 20; k++) begin
            @(posedge clk);
            if (waitrequest === 1'b0) break;
        end
        rd = readdata;
        read  <= 1'b0;
        write <= 1'b0;
        // Returning mid-cycle lets callers look at outputs after the completing edge has settled.
        @(negedge clk);
        if (k == 20) begin
            n_mismatch++;
            $display("MISMATCH t=%0t bus hang got=%h exp=%h", $time, waitrequest, 1'b0);
            report_and_stop();
        end
    endtask

    task automatic wr_reg(input logic [11:0] a, input logic [31:0] d);
        bus(1'b1, a, d, 4'hF);
    endtask

    task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0000_0000, 4'hF);
        check(rd, exp);
    endtask

    task automatic pulse_ev(input unit_events_s v);
        @(posedge clk);
        unit_events <= v;
        @(posedge clk);
        unit_events <= '0;
        repeat (3) @(posedge clk);
    endtask

    task automatic chk_irq(input logic s, input logic i);
        repeat (2) @(negedge clk);
        check({31'h0, event_irq_summary}, {31'h0, s});
        check({31'h0, irq}, {31'h0, i});
    endtask

    // ****************************************
    // Scenarios
    // ****************************************
    task automatic test_reset();
        rd_chk(OFS_UNIT_SELECTOR, 32'h0000_0000);
        rd_chk(OFS_TRIG_STATUS, 32'h0000_0000);
        rd_chk(OFS_EVENT_IRQ, 32'h0000_0000);
        check({21'h0, unit_ctrl}, 32'h0000_0000);
        chk_irq(1'b0, 1'b0);
        $display("test_reset done");
    endtask

    task automatic test_selector();
        wr_reg(OFS_UNIT_SELECTOR, 32'hFFFF_FFFF);
        rd_chk(OFS_UNIT_SELECTOR, 32'h0000_0103);
        wr_reg(OFS_STAMP_CONTROL, 32'h0000_0008);
        check({29'h0, unit_ctrl.pulse_enable}, 32'h0000_0000);
        bus(1'b1, OFS_UNIT_SELECTOR, 32'h0000_0000, 4'h1);
        rd_chk(OFS_UNIT_SELECTOR, 32'h0000_0100);
        $display("test_selector done");
    endtask

    task automatic test_window();
        for (int i = 0; i < 3; i++) begin
            wr_reg(OFS_UNIT_SELECTOR, i);
            wr_reg(OFS_STAMP_CONTROL, 32'h0000_0008);
            check({29'h0, unit_ctrl.pulse_enable}, (32'h1 << (i + 1)) - 32'h1);
            rd_chk(OFS_STAMP_CONTROL, 32'h0000_0018);
        end
        wr_reg(OFS_UNIT_SELECTOR, 32'h0000_0102);
        wr_reg(OFS_STAMP_CONTROL, 32'h0000_0028);
        check({30'h0, unit_ctrl.stamp_irq_enable}, 32'h0000_0002);
        check({29'h0, unit_ctrl.pulse_enable}, 32'h0000_0007);
        $display("test_window done");
    endtask

    task automatic test_error();
        wr_reg(OFS_UNIT_SELECTOR, 32'h0000_0001);
        wr_reg(OFS_PULSE_CONTROL, 32'h0000_0001);
        rd_chk(OFS_PULSE_CONTROL, 32'h0000_0001);
        check({29'h0, unit_ctrl.pulse_notify_enable}, 32'h0000_0002);
        pulse_ev('{pulse_error: 3'h7, pulse_done: 3'h0, stamp_event: 2'h0});
        rd_chk(OFS_TRIG_STATUS, 32'h0002_0000);
        rd_chk(OFS_EVENT_IRQ, 32'h0002_0000);
        chk_irq(1'b1, 1'b0);
        wr_reg(OFS_EVENT_IRQ_MASK, 32'hFFFF_FFFF);
        rd_chk(OFS_EVENT_IRQ_MASK, 32'h0007_0003);
        chk_irq(1'b1, 1'b1);
        rd_chk(OFS_STAMP_CONTROL, 32'h0000_0008);
        wr_reg(OFS_STAMP_CONTROL, 32'h0000_0000);
        rd_chk(OFS_TRIG_STATUS, 32'h0000_0000);
        wr_reg(OFS_EVENT_IRQ, 32'h0002_0000);
        rd_chk(OFS_EVENT_IRQ, 32'h0000_0000);
        chk_irq(1'b0, 1'b0);
        $display("test_error done");
    endtask

    task automatic test_done();
        wr_reg(OFS_STAMP_CONTROL, 32'h0000_0008);
        wr_reg(OFS_UNIT_SELECTOR, 32'h0000_0000);
        wr_reg(OFS_PULSE_CONTROL, 32'h0000_0001);
        wr_reg(OFS_UNIT_SELECTOR, 32'h0000_0002);
        wr_reg(OFS_PULSE_CONTROL, 32'h0000_0001);
        check({29'h0, unit_ctrl.pulse_notify_enable}, 32'h0000_0007);
        pulse_ev('{pulse_error: 3'h1, pulse_done: 3'h7, stamp_event: 2'h0});
        check({29'h0, unit_ctrl.pulse_enable}, 32'h0000_0000);
        rd_chk(OFS_TRIG_STATUS, 32'h0001_0007);
        rd_chk(OFS_EVENT_IRQ, 32'h0007_0000);
        wr_reg(OFS_TRIG_STATUS, 32'h0000_0002);
        rd_chk(OFS_TRIG_STATUS, 32'h0001_0005);
        wr_reg(OFS_EVENT_IRQ, 32'hFFFF_FFFF);
        rd_chk(OFS_EVENT_IRQ, 32'h0000_0000);
        $display("test_done done");
    endtask

    task automatic test_stamp();
        pulse_ev('{pulse_error: 3'h0, pulse_done: 3'h0, stamp_event: 2'h3});
        rd_chk(OFS_EVENT_IRQ, 32'h0000_0002);
        chk_irq(1'b1, 1'b1);
        wr_reg(OFS_EVENT_IRQ_MASK, 32'h0000_0000);
        chk_irq(1'b1, 1'b0);
        wr_reg(OFS_EVENT_IRQ, 32'h0000_0002);
        rd_chk(OFS_EVENT_IRQ, 32'h0000_0000);
        chk_irq(1'b0, 1'b0);
        $display("test_stamp done");
    endtask

    task automatic test_unmapped();
        wr_reg(12'h7F0, 32'hFFFF_FFFF);
        rd_chk(12'h7F0, 32'h0000_0000);
        rd_chk(OFS_UNIT_SELECTOR, 32'h0000_0002);
        $display("test_unmapped done");
    endtask

    initial begin
        clk          = 1'b0;
        rst          = 1'b1;
        address      = '0;
        read         = 1'b0;
        write        = 1'b0;
        byteenable   = 4'hF;
        writedata    = 32'h0000_0000;
        unit_events  = '0;
        n_mismatch   = 0;
        total_checks = 0;
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        test_reset();
        test_selector();
        test_window();
        test_error();
        test_done();
        test_stamp();
        test_unmapped();
        report_and_stop();
    end
endmodule
